// ---- design/jsp_map.svh ----
// Constants for the test and debug port block
`ifndef JSP_MAP_SVH
`define JSP_MAP_SVH
`define JSP_IR_WIDTH 4
`define JSP_IR_RESET 4'h1
`define JSP_IR_BYPASS 4'hf
`define JSP_IR_EMUCTL 4'h2
`define JSP_IR_IDCODE 4'h1
`define JSP_EMU_CTL_WIDTH 4
`define JSP_EMU_CTL_RESET 4'h0
`define JSP_IDCODE_VALUE 32'h1234_5671
`endif

// ---- design/jsp_pkg.sv ----
// Types shared by the test and debug port block
package jsp_pkg;
  typedef enum logic [15:0] {
    JSP_RESET = 16'h0001,
    JSP_IDLE = 16'h0002,
    JSP_SEL_DR = 16'h0004,
    JSP_CAP_DR = 16'h0008,
    JSP_SHIFT_DR = 16'h0010,
    JSP_EXIT1_DR = 16'h0020,
    JSP_PAUSE_DR = 16'h0040,
    JSP_EXIT2_DR = 16'h0080,
    JSP_UPD_DR = 16'h0100,
    JSP_SEL_IR = 16'h0200,
    JSP_CAP_IR = 16'h0400,
    JSP_SHIFT_IR = 16'h0800,
    JSP_EXIT1_IR = 16'h1000,
    JSP_PAUSE_IR = 16'h2000,
    JSP_EXIT2_IR = 16'h4000,
    JSP_UPD_IR = 16'h8000
  } jsp_tap_state_t;
  // Emulator pin pair: input, output, output enable
  typedef struct packed {
    logic a;
    logic b;
  } jsp_emu_pair_t;
endpackage : jsp_pkg

// ---- design/jsp_debug_port.sv ----
// Test access port, scan output and emulator pins of the debug port
// Function
// R1 - Test reset high hands device to scan
// R2 - Test reset low: functional mode, scan ignored
// R3 - Probe keeps test reset low normally
// R4 - Mode select sampled on test clock rise
// R5 - Data in captured on test clock rise
// R6 - Data out changes on test clock fall
// R7 - Emulator pins are scan-directed interrupt lines
// R8 - Pin a high, b low latches boundary-scan
// R9 - Standard sixteen-state TAP controller
// R10 - Data out driven only in shift states
`timescale 1ns/1ps
`default_nettype none
`include "jsp_map.svh"
module jsp_debug_port
  import jsp_pkg::*;
#(
  parameter int IR_WIDTH = `JSP_IR_WIDTH,
  parameter int EMU_WIDTH = `JSP_EMU_CTL_WIDTH,
  parameter logic [31:0] ID_VALUE = `JSP_IDCODE_VALUE // Arbitrary value
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic tck_in,
  input wire logic test_reset_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  input wire jsp_emu_pair_t emu_pin_in,
  output jsp_emu_pair_t emu_pin_out,
  output jsp_emu_pair_t emu_pin_oe_out,
  input wire jsp_emu_pair_t emu_event_in,
  output jsp_emu_pair_t emu_event_out,
  output logic scan_control_out,
  output logic boundary_scan_out
);
  jsp_tap_state_t tap_reg, tap_next;
  logic [IR_WIDTH-1:0] ir_shift_reg, ir_reg;
  logic [31:0] dr_shift_reg;
  logic [EMU_WIDTH-1:0] emu_ctl_reg;
  logic tdo_reg, tdo_oe_reg;
  logic trst_q_reg;
  logic bscan_reg;
  jsp_emu_pair_t emu_in_s1_reg, emu_in_s2_reg;
  jsp_emu_pair_t ev_s1_reg, ev_s2_reg;
  logic trst_s1_reg, trst_s2_reg, bscan_s1_reg, bscan_s2_reg;

  // Next TAP state from mode select [R9]
  always_comb begin
    case (tap_reg)
      JSP_RESET: tap_next = tms_in ? JSP_RESET : JSP_IDLE;
      JSP_IDLE: tap_next = tms_in ? JSP_SEL_DR : JSP_IDLE;
      JSP_SEL_DR: tap_next = tms_in ? JSP_SEL_IR : JSP_CAP_DR;
      JSP_CAP_DR: tap_next = tms_in ? JSP_EXIT1_DR : JSP_SHIFT_DR;
      JSP_SHIFT_DR: tap_next = tms_in ? JSP_EXIT1_DR : JSP_SHIFT_DR;
      JSP_EXIT1_DR: tap_next = tms_in ? JSP_UPD_DR : JSP_PAUSE_DR;
      JSP_PAUSE_DR: tap_next = tms_in ? JSP_EXIT2_DR : JSP_PAUSE_DR;
      JSP_EXIT2_DR: tap_next = tms_in ? JSP_UPD_DR : JSP_SHIFT_DR;
      JSP_UPD_DR: tap_next = tms_in ? JSP_SEL_DR : JSP_IDLE;
      JSP_SEL_IR: tap_next = tms_in ? JSP_RESET : JSP_CAP_IR;
      JSP_CAP_IR: tap_next = tms_in ? JSP_EXIT1_IR : JSP_SHIFT_IR;
      JSP_SHIFT_IR: tap_next = tms_in ? JSP_EXIT1_IR : JSP_SHIFT_IR;
      JSP_EXIT1_IR: tap_next = tms_in ? JSP_UPD_IR : JSP_PAUSE_IR;
      JSP_PAUSE_IR: tap_next = tms_in ? JSP_EXIT2_IR : JSP_PAUSE_IR;
      JSP_EXIT2_IR: tap_next = tms_in ? JSP_UPD_IR : JSP_SHIFT_IR;
      JSP_UPD_IR: tap_next = tms_in ? JSP_SEL_DR : JSP_IDLE;
      default: tap_next = JSP_RESET;
    endcase
  end

  // TAP held in reset while test reset is low; the pin is the test
  // reset itself, so its edges are taken raw in the test clock domain
  always_ff @(posedge tck_in or negedge test_reset_in) begin
    if (!test_reset_in) begin
      tap_reg <= JSP_RESET; // [R2]
    end else begin
      tap_reg <= tap_next; // [R4] [R9]
    end
  end

  // Instruction shift and update, captured on rising edge
  always_ff @(posedge tck_in or negedge test_reset_in) begin
    if (!test_reset_in) begin
      ir_shift_reg <= IR_WIDTH'(`JSP_IR_RESET);
      ir_reg <= IR_WIDTH'(`JSP_IR_RESET);
    end else begin
      case (tap_reg)
        JSP_CAP_IR: ir_shift_reg <= IR_WIDTH'(`JSP_IR_RESET);
        JSP_SHIFT_IR: ir_shift_reg <= {tdi_in, ir_shift_reg[IR_WIDTH-1:1]}; // [R5]
        JSP_UPD_IR: ir_reg <= ir_shift_reg;
        JSP_RESET: ir_reg <= IR_WIDTH'(`JSP_IR_RESET);
        default: ir_reg <= ir_reg;
      endcase
    end
  end

  // Data register: identity, emulator control or bypass
  always_ff @(posedge tck_in or negedge test_reset_in) begin
    if (!test_reset_in) begin
      dr_shift_reg <= 32'h0000_0000;
    end else if (tap_reg == JSP_CAP_DR) begin
      case (ir_reg)
        IR_WIDTH'(`JSP_IR_IDCODE): dr_shift_reg <= ID_VALUE;
        IR_WIDTH'(`JSP_IR_EMUCTL): dr_shift_reg <= {28'h0000000, emu_ctl_reg};
        default: dr_shift_reg <= 32'h0000_0000;
      endcase
    end else if (tap_reg == JSP_SHIFT_DR) begin
      case (ir_reg)
        IR_WIDTH'(`JSP_IR_IDCODE): dr_shift_reg <= {tdi_in, dr_shift_reg[31:1]}; // [R5]
        IR_WIDTH'(`JSP_IR_EMUCTL):
          dr_shift_reg <= {28'h0000000, tdi_in, dr_shift_reg[EMU_WIDTH-1:1]}; // [R5]
        default: dr_shift_reg <= {31'h00000000, tdi_in}; // [R5]
      endcase
    end
  end

  // Emulator control: bit 0/1 drive enables a/b, bit 2/3 drive values
  always_ff @(posedge tck_in or negedge test_reset_in) begin
    if (!test_reset_in) begin
      emu_ctl_reg <= EMU_WIDTH'(`JSP_EMU_CTL_RESET);
    end else if (tap_reg == JSP_UPD_DR && ir_reg == IR_WIDTH'(`JSP_IR_EMUCTL)) begin
      emu_ctl_reg <= dr_shift_reg[EMU_WIDTH-1:0]; // [R7]
    end
  end

  // Output changes on falling edge so probe samples a settled bit
  always_ff @(negedge tck_in or negedge test_reset_in) begin
    if (!test_reset_in) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg <= (tap_reg == JSP_SHIFT_IR) ? ir_shift_reg[0] : dr_shift_reg[0]; // [R6]
      tdo_oe_reg <= (tap_reg == JSP_SHIFT_IR) || (tap_reg == JSP_SHIFT_DR); // [R10]
    end
  end

  assign tdo_out = tdo_reg;
  assign tdo_oe_out = tdo_oe_reg; // [R10]

  // Emulator pins drive only under scan control, direction from scan [R7]
  assign emu_pin_oe_out.a = test_reset_in & emu_ctl_reg[0];
  assign emu_pin_oe_out.b = test_reset_in & emu_ctl_reg[1];
  assign emu_pin_out.a = emu_ctl_reg[2];
  assign emu_pin_out.b = emu_ctl_reg[3];

  // Pins into the system clock domain through two flip-flops
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      trst_s1_reg <= 1'b0;
      trst_s2_reg <= 1'b0;
      emu_in_s1_reg <= '0;
      emu_in_s2_reg <= '0;
      bscan_s1_reg <= 1'b0;
      bscan_s2_reg <= 1'b0;
    end else begin
      trst_s1_reg <= test_reset_in;
      trst_s2_reg <= trst_s1_reg;
      emu_in_s1_reg <= emu_pin_in;
      emu_in_s2_reg <= emu_in_s1_reg;
      bscan_s1_reg <= bscan_reg;
      bscan_s2_reg <= bscan_s1_reg;
    end
  end

  // Events toward the probe, synchronised into the link domain
  always_ff @(posedge tck_in or negedge test_reset_in) begin
    if (!test_reset_in) begin
      ev_s1_reg <= '0;
      ev_s2_reg <= '0;
    end else begin
      ev_s1_reg <= emu_event_in;
      ev_s2_reg <= ev_s1_reg;
    end
  end

  // Boundary-scan latch: strap sampled at the test reset rise [R8]
  always_ff @(posedge test_reset_in) begin
    bscan_reg <= emu_pin_in.a & ~emu_pin_in.b; // [R8]
  end

  // Direction bits into the system clock through two flip-flops; they
  // only move on a scan update or a test reset, long before an event is looked at.
  // Reading the test clock register raw here would risk a metastable gate.
  logic [1:0] oe_s1_reg, oe_s2_reg;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      oe_s1_reg <= 2'h0;
      oe_s2_reg <= 2'h0;
    end else begin
      oe_s1_reg <= emu_ctl_reg[1:0];
      oe_s2_reg <= oe_s1_reg;
    end
  end

  // Direction of one emulator pin as seen in the system clock
  function automatic logic emu_ctl_reg_sync(input int idx);
    emu_ctl_reg_sync = oe_s2_reg[idx];
  endfunction : emu_ctl_reg_sync

  // Incoming debug interrupts only count under scan control [R1] [R2]
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      emu_event_out <= '0;
      trst_q_reg <= 1'b0;
    end else begin
      trst_q_reg <= trst_s2_reg;
      emu_event_out.a <= trst_s2_reg & ~emu_ctl_reg_sync(0) & emu_in_s2_reg.a; // [R7]
      emu_event_out.b <= trst_s2_reg & ~emu_ctl_reg_sync(1) & emu_in_s2_reg.b; // [R7]
    end
  end

  assign scan_control_out = trst_q_reg; // [R1] [R2]
  assign boundary_scan_out = trst_q_reg & bscan_s2_reg; // [R8]

  // Probe-side events are synchronised but drive no output; they only fold into unused_ev
  logic unused_ev;
  assign unused_ev = ^ev_s2_reg;

  // Checks in the test clock and system clock domains
  tap_reset_hold_a: assert property (@(posedge tck_in) !test_reset_in |-> ##1
    (tap_reg == JSP_RESET || test_reset_in)) else $error("TAP not reset"); // [R2]
  shift_sel_a: assert property (@(posedge tck_in) disable iff (!test_reset_in)
    tap_reg == JSP_SHIFT_DR && tms_in |=> tap_reg == JSP_EXIT1_DR)
    else $error("Shift exit wrong"); // [R4]
  five_ones_a: assert property (@(posedge tck_in) disable iff (!test_reset_in)
    tms_in [*5] |=> tap_reg == JSP_RESET) else $error("Five ones no reset"); // [R9]
  ir_shift_a: assert property (@(posedge tck_in) disable iff (!test_reset_in)
    tap_reg == JSP_SHIFT_IR |=> ir_shift_reg[IR_WIDTH-1] == $past(tdi_in))
    else $error("IR capture wrong"); // [R5]
  tdo_enable_a: assert property (@(negedge tck_in) disable iff (!test_reset_in)
    1'b1 |=> tdo_oe_out == ($past(tap_reg) inside {JSP_SHIFT_DR, JSP_SHIFT_IR}))
    else $error("TDO enable wrong"); // [R10]
  tdo_bit_a: assert property (@(negedge tck_in) disable iff (!test_reset_in)
    tap_reg == JSP_SHIFT_IR |=> tdo_out == $past(ir_shift_reg[0]))
    else $error("TDO bit wrong"); // [R6]
  emu_dir_a: assert property (@(posedge tck_in) disable iff (!test_reset_in)
    emu_pin_oe_out.a == emu_ctl_reg[0]) else $error("Emu direction wrong"); // [R7]
  emu_idle_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !trst_q_reg |-> emu_event_out == '0 && !boundary_scan_out)
    else $error("Events outside scan"); // [R2]
  scan_ctl_a: assert property (@(posedge clk_in) disable iff (reset_in)
    trst_s2_reg |=> scan_control_out) else $error("Scan control lost"); // [R1]
  strap_a: assert property (@(posedge clk_in) disable iff (reset_in)
    boundary_scan_out |-> scan_control_out) else $error("Bscan without scan"); // [R8]

  // Further walk checks; every antecedent is reached by ordinary scans
  cap_shift_a: assert property (@(posedge tck_in) disable iff (!test_reset_in) // [R9]
    tap_reg == JSP_CAP_DR && !tms_in |=> tap_reg == JSP_SHIFT_DR)
    else $error("Capture exit wrong");
  ir_exit_a: assert property (@(posedge tck_in) disable iff (!test_reset_in) // [R9]
    tap_reg == JSP_SHIFT_IR && tms_in |=> tap_reg == JSP_EXIT1_IR)
    else $error("Instruction exit wrong");
  upd_idle_a: assert property (@(posedge tck_in) disable iff (!test_reset_in) // [R9]
    tap_reg == JSP_UPD_DR && !tms_in |=> tap_reg == JSP_IDLE)
    else $error("Update exit wrong");
  ir_update_a: assert property (@(posedge tck_in) disable iff (!test_reset_in) // [R9]
    tap_reg == JSP_UPD_IR |=> ir_reg == $past(ir_shift_reg))
    else $error("Instruction update wrong");
  ir_reset_a: assert property (@(posedge tck_in) disable iff (!test_reset_in) // [R9]
    tap_reg == JSP_RESET |=> ir_reg == IR_WIDTH'(`JSP_IR_RESET))
    else $error("Instruction not reset");

  // Data path: bits enter at the top and leave at the bottom
  dr_shift_a: assert property (@(posedge tck_in) disable iff (!test_reset_in) // [R5]
    tap_reg == JSP_SHIFT_DR && ir_reg == IR_WIDTH'(`JSP_IR_IDCODE) |=>
    dr_shift_reg[31] == $past(tdi_in)) else $error("Data capture wrong");
  tdo_dr_a: assert property (@(negedge tck_in) disable iff (!test_reset_in) // [R6]
    tap_reg == JSP_SHIFT_DR |=> tdo_out == $past(dr_shift_reg[0]))
    else $error("Data out bit wrong");
  ctl_update_a: assert property (@(posedge tck_in) disable iff (!test_reset_in) // [R7]
    tap_reg == JSP_UPD_DR && ir_reg == IR_WIDTH'(`JSP_IR_EMUCTL) |=>
    emu_ctl_reg == $past(dr_shift_reg[EMU_WIDTH-1:0])) else $error("Control update wrong");

  // System clock side: pins released and events gated outside scan
  emu_oe_off_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R2]
    !test_reset_in |-> emu_pin_oe_out == '0)
    else $error("Emulator pin driven");
  ev_gate_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R7]
    emu_event_out.a |-> !$past(oe_s2_reg[0]) && $past(trst_s2_reg))
    else $error("Event from driven pin");
  scan_drop_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R2]
    !trst_s2_reg |=> !scan_control_out)
    else $error("Scan control kept");
  bscan_hold_a: assert property (@(posedge clk_in) disable iff (reset_in) // [R8]
    trst_q_reg && $past(trst_q_reg) |-> $stable(bscan_s2_reg))
    else $error("Strap moved in scan");
  ir_cover_c: cover property (@(posedge tck_in) tap_reg == JSP_UPD_IR);
  dr_cover_c: cover property (@(posedge tck_in) tap_reg == JSP_UPD_DR);
  bscan_cover_c: cover property (@(posedge clk_in) boundary_scan_out);
  shift_cover_c: cover property (@(posedge tck_in) tap_reg == JSP_SHIFT_DR);
  event_cover_c: cover property (@(posedge clk_in) emu_event_out.b);
endmodule : jsp_debug_port
`default_nettype wire

// ---- tb/jsp_probe.sv ----
// Behavioural debug probe driving the test access port
`timescale 1ns/1ps
`default_nettype none
module jsp_probe (
  input wire logic tdo_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  output logic trst_out
);
  // Idle: clock parked low, pulled-up lines high, test reset low
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
    trst_out = 1'b0;
  end
  // Test reset only moves when a scenario takes or releases scan control
  task automatic set_trst(input logic v);
    trst_out = v;
  endtask : set_trst
  // One 30 ns clock; lines settle half a period before the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms_out = m;
    tdi_out = d;
    #15;
    o = tdo_in;
    tck_out = 1'b1;
    #15;
    tck_out = 1'b0;
  endtask : step
  // Five ones reach reset from any state, then park in idle
  task automatic tap_reset();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask : tap_reset
  // Idle to shift, n bits LSB first, exit on the last, update, idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask : scan
endmodule : jsp_probe
`default_nettype wire

// ---- tb/jtag_scan_and_emu_pins_test.sv ----
// Self-checking bench for the debug port block
`timescale 1ns/1ps
`default_nettype none
`include "jsp_map.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module jtag_scan_and_emu_pins_test;
  import jsp_pkg::*;
  logic clk_in, reset_in, tck, tms, tdi, trst, tdo, tdo_oe, tdo_wire, scan_ctl, bscan;
  jsp_emu_pair_t emu_drv, emu_wire, pin_out, pin_oe, ev_in, ev_out;
  logic [31:0] dout;
  int miscompares = 0;
  int cmp_count = 0;
  // Released lines: toggling data out, pulled-up emulator pins
  assign tdo_wire = tdo_oe ? tdo : clk_in;
  assign emu_wire = {pin_oe.a ? pin_out.a : emu_drv.a, pin_oe.b ? pin_out.b : emu_drv.b};
  jsp_debug_port jsp_debug_port_inst (.clk_in(clk_in), .reset_in(reset_in), .tck_in(tck),
    .test_reset_in(trst), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
    .emu_pin_in(emu_wire), .emu_pin_out(pin_out), .emu_pin_oe_out(pin_oe),
    .emu_event_in(ev_in), .emu_event_out(ev_out), .scan_control_out(scan_ctl),
    .boundary_scan_out(bscan));
  jsp_probe jsp_probe_inst (.tdo_in(tdo_wire), .tck_out(tck), .tms_out(tms), .tdi_out(tdi),
    .trst_out(trst));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  // Test reset low: clocking the port must not wake scan logic
  task automatic t_func();
    jsp_probe_inst.tap_reset();
    jsp_probe_inst.scan(1'b0, 32'h0, 8, dout);
    `CHK(tdo_oe, 1'b0)
    `CHK(scan_ctl, 1'b0)
    `CHK(pin_oe, 2'b00)
    $display("t_func done");
  endtask : t_func
  // Strap pins at the rise of test reset pick boundary-scan mode
  task automatic t_strap(input logic a, input logic b, input logic e);
    @(negedge clk_in);
    emu_drv = {a, b};
    repeat (2) @(negedge clk_in);
    jsp_probe_inst.set_trst(1'b1);
    repeat (8) @(negedge clk_in);
    `CHK(scan_ctl, 1'b1)
    `CHK(bscan, e)
    jsp_probe_inst.set_trst(1'b0);
    repeat (8) @(negedge clk_in);
    `CHK(scan_ctl, 1'b0)
    $display("t_strap done");
  endtask : t_strap
  // Identity read after reset, bypass delay of one bit
  task automatic t_scan();
    @(negedge clk_in);
    jsp_probe_inst.set_trst(1'b1);
    jsp_probe_inst.tap_reset();
    jsp_probe_inst.scan(1'b0, 32'h0, 32, dout);
    `CHK(dout, `JSP_IDCODE_VALUE)
    `CHK(tdo_oe, 1'b0)
    jsp_probe_inst.scan(1'b1, {28'h0, `JSP_IR_BYPASS}, 4, dout);
    `CHK(dout[1:0], 2'b01)
    jsp_probe_inst.scan(1'b0, 32'ha5, 8, dout);
    `CHK(dout[7:0], 8'h4a)
    $display("t_scan done");
  endtask : t_scan
  // Pin a made an output, pin b stays an event input
  task automatic t_emu();
    jsp_probe_inst.scan(1'b1, {28'h0, `JSP_IR_EMUCTL}, 4, dout);
    jsp_probe_inst.scan(1'b0, 32'h5, 4, dout);
    `CHK(pin_oe, 2'b10)
    `CHK(pin_out.a, 1'b1)
    `CHK(pin_out.b, 1'b0)
    @(negedge clk_in);
    emu_drv = 2'b01;
    repeat (8) @(negedge clk_in);
    `CHK(ev_out, 2'b01)
    $display("t_emu done");
  endtask : t_emu
  // Watchdog well beyond the roughly one hundred test clocks used
  initial begin
    #100us;
    miscompares++;
    conclude();
  end
  initial begin
    reset_in = 1'b1;
    emu_drv = 2'b11;
    ev_in = 2'b00;
    repeat (10) @(negedge clk_in);
    reset_in = 1'b0;
    t_func();
    t_strap(1'b1, 1'b0, 1'b1);
    t_strap(1'b0, 1'b0, 1'b0);
    t_scan();
    t_emu();
    conclude();
  end
endmodule : jtag_scan_and_emu_pins_test
`default_nettype wire
